//--- breaker_failure_unit.sv
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module breaker_failure_unit
  import bf_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [DATA_W-1:0] pwdata_i,
  output logic      [DATA_W-1:0] prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              trip_all_i,
  input  wire logic              trip_ext_i,
  input  wire logic              trip_cur_i,
  input  wire logic [THR_W-1:0]  current_i,
  input  wire logic              pos_open_aux_i,
  input  wire logic              pos_closed_aux_i,
  input  wire logic              extra_start_input_a_i,
  input  wire logic              extra_start_input_b_i,
  input  wire logic              extra_start_input_c_i,
  output logic                   backup_trip_o,
  output logic                   lock_o
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_r;
  logic [THR_W-1:0]  thr_r  [NUM_SETS];
  logic [TIME_W-1:0] time_r [NUM_SETS];
  logic [DATA_W-1:0] prdata_r;
  logic              pready_r;
  logic              pslverr_r;
  logic [TICK_W-1:0] tick_cnt_r;
  logic              tick_r;
  logic              trig_seen_r;
  logic [TIME_W-1:0] timer_r;
  logic [TIME_W-1:0] timer_nxt;
  bf_state_t         state_r;
  bf_state_t         state_nxt;
  logic              backup_trip_r;
  logic              lock_r;

  logic              access;
  logic              commit;
  logic              set_hit;
  logic [ADDR_W-1:0] set_off;
  logic              mapped;
  logic [1:0]        set_idx;
  logic [DATA_W-1:0] rd_data;
  logic [1:0]        scheme;
  logic [1:0]        trig_mode;
  logic [1:0]        act_set;
  logic [2:0]        extra_en;
  logic [2:0]        extra_lvl;
  logic              assigned_trip;
  logic              trig_now;
  logic              trig_any;
  logic [THR_W-1:0]  thr_sel;
  logic [TIME_W-1:0] time_sel;
  logic              cur_high;
  logic              pos_open;
  logic              opened;
  logic              fail_cond;
  logic              ack_wr;

  pin_sync_if pins ();

  // ---------------------------------------------------------------
  // pin capture
  // ---------------------------------------------------------------
  // position contacts and extra start inputs arrive as raw pins
  assign pins.raw[PIN_OPEN]        = pos_open_aux_i;
  assign pins.raw[PIN_CLOSED]      = pos_closed_aux_i;
  assign pins.raw[PIN_EXTRA_LSB]   = extra_start_input_a_i;
  assign pins.raw[PIN_EXTRA_LSB+1] = extra_start_input_b_i;
  assign pins.raw[PIN_EXTRA_LSB+2] = extra_start_input_c_i;

  pin_sync u_pin_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .pins    (pins.filter)
  );

  // ---------------------------------------------------------------
  // apb slave: one wait state, answer in the second access cycle
  // ---------------------------------------------------------------
  assign access  = psel_i & penable_i;
  assign commit  = access & pready_r;
  assign set_hit = (paddr_i >= OFF_SET_BASE) && (paddr_i <= OFF_SET_LAST);
  // sets are eight bytes apart, counted from the set base, not from zero
  assign set_off = paddr_i - OFF_SET_BASE;
  assign set_idx = set_off[SET_IDX_LSB+1:SET_IDX_LSB];
  assign mapped  = (paddr_i[1:0] == 2'h0) &&
                   ((paddr_i == OFF_CTRL) || (paddr_i == OFF_ACK) ||
                    (paddr_i == OFF_STATUS) || set_hit);
  assign ack_wr  = commit & pwrite_i & (paddr_i == OFF_ACK) & pwdata_i[ACK_BIT];

  always_comb begin
    rd_data = '0;
    if (paddr_i == OFF_CTRL) begin
      rd_data[CTRL_W-1:0] = ctrl_r;
    end else if (paddr_i == OFF_STATUS) begin
      rd_data[3:0]         = state_r;
      rd_data[ST_TRIP_BIT] = backup_trip_r;
      rd_data[ST_LOCK_BIT] = lock_r;
      rd_data[ST_OPEN_BIT] = pos_open;
      rd_data[ST_HIGH_BIT] = cur_high;
      rd_data[ST_TRIG_BIT] = trig_now;
    end else if (set_hit && paddr_i[SET_TIME_BIT]) begin
      rd_data[TIME_W-1:0] = time_r[set_idx];
    end else if (set_hit) begin
      rd_data[THR_W-1:0] = thr_r[set_idx];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r <= access & ~pready_r;
      if (access && !pready_r) begin
        pslverr_r <= ~mapped;
        prdata_r  <= (mapped && !pwrite_i) ? rd_data : '0;
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_r <= CTRL_RST;
    end else if (commit && pwrite_i && paddr_i == OFF_CTRL) begin
      ctrl_r <= pwdata_i[CTRL_W-1:0];
    end
  end

  genvar s;
  generate
    for (s = 0; s < NUM_SETS; s++) begin : g_set
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          thr_r[s]  <= THR_RST;
          time_r[s] <= TIME_RST;
        end else if (commit && pwrite_i && set_hit && set_idx == 2'(s)) begin
          if (paddr_i[SET_TIME_BIT]) begin
            time_r[s] <= pwdata_i[TIME_W-1:0];
          end else begin
            thr_r[s] <= pwdata_i[THR_W-1:0];
          end
        end
      end
    end
  endgenerate

  assign scheme    = ctrl_r[CTRL_SCHEME_LSB+1:CTRL_SCHEME_LSB];
  assign trig_mode = ctrl_r[CTRL_TRIG_LSB+1:CTRL_TRIG_LSB];
  assign act_set   = ctrl_r[CTRL_SET_LSB+1:CTRL_SET_LSB];
  assign extra_en  = ctrl_r[CTRL_EXTRA_LSB+2:CTRL_EXTRA_LSB];
  // settings follow the active parameter set
  assign thr_sel   = thr_r[act_set];
  assign time_sel  = time_r[act_set];

  // ---------------------------------------------------------------
  // trigger selection
  // ---------------------------------------------------------------
  always_comb begin
    assigned_trip = 1'b0;
    case (trig_mode)
      MODE_ALL:        assigned_trip = trip_all_i;
      MODE_EXTERNAL:   assigned_trip = trip_ext_i;
      MODE_CURRENT:    assigned_trip = trip_cur_i;
      MODE_UNASSIGNED: assigned_trip = 1'b0;
      default:         assigned_trip = 1'b0;
    endcase
  end

  // extra inputs act whatever the trip assignment
  assign extra_lvl = pins.clean[PIN_EXTRA_LSB+2:PIN_EXTRA_LSB] & extra_en;
  assign trig_now  = assigned_trip | (|extra_lvl);
  assign trig_any  = trig_now | trig_seen_r;

  // ---------------------------------------------------------------
  // processing tick
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == TICK_W'(TICK_CYCLES_P - 1)) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
      tick_r     <= 1'b0;
    end
  end

  // a trigger pulse shorter than a tick must still start supervision
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trig_seen_r <= 1'b0;
    end else if (tick_r) begin
      // the tick that clears the flag reads trig_now itself, so nothing is lost
      trig_seen_r <= 1'b0;
    end else if (trig_now) begin
      trig_seen_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // breaker evaluation
  // ---------------------------------------------------------------
  // at or above the threshold counts as current still flowing
  assign cur_high = (current_i >= thr_sel);
  // open only when the open contact is made and the closed one is not
  assign pos_open = pins.clean[PIN_OPEN] & ~pins.clean[PIN_CLOSED];

  always_comb begin
    opened    = ~cur_high;
    fail_cond = cur_high;
    case (scheme)
      SCHEME_CURRENT: begin
        opened    = ~cur_high;
        fail_cond = cur_high;
      end
      SCHEME_POSITION: begin
        opened    = pos_open;
        fail_cond = ~pos_open;
      end
      SCHEME_COMBINED: begin
        // both must confirm to stop early; either clears at expiry
        opened    = ~cur_high & pos_open;
        fail_cond = cur_high & ~pos_open;
      end
      default: begin
        opened    = ~cur_high;
        fail_cond = cur_high;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // supervision state machine, advanced on each tick
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    case (state_r)
      ST_STANDBY: begin
        if (trig_any && opened) begin
          // breaker already clear: no pickup at all
          state_nxt = ST_REJECTED;
        end else if (trig_any) begin
          state_nxt = ST_RUNNING;
          timer_nxt = time_sel;
        end
      end
      ST_RUNNING: begin
        // trigger level is not consulted while counting
        if (opened) begin
          state_nxt = trig_now ? ST_REJECTED : ST_STANDBY;
        end else if (timer_r <= TIME_W'(1)) begin
          if (fail_cond) begin
            state_nxt = ST_FAILED;
          end else begin
            state_nxt = trig_now ? ST_REJECTED : ST_STANDBY;
          end
          timer_nxt = '0;
        end else begin
          timer_nxt = timer_r - 1'b1;
        end
      end
      ST_REJECTED: begin
        if (!trig_now) begin
          state_nxt = ST_STANDBY;
        end
      end
      ST_FAILED: begin
        if (!trig_now) begin
          state_nxt = ST_STANDBY;
        end
      end
      default: begin
        state_nxt = ST_STANDBY;
        timer_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= ST_STANDBY;
      timer_r <= '0;
    end else if (tick_r) begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
    end
  end

  // ---------------------------------------------------------------
  // backup trip and lock
  // ---------------------------------------------------------------
  // trip is held for at least one tick so a relay can pick it up
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      backup_trip_r <= 1'b0;
    end else if (tick_r) begin
      backup_trip_r <= (state_nxt == ST_FAILED);
    end
  end

  // lock rises on the same edge as the trip; a new failure beats an ack
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_r <= 1'b0;
    end else if (tick_r && state_nxt == ST_FAILED) begin
      lock_r <= 1'b1;
    end else if (ack_wr) begin
      lock_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata_o      = prdata_r;
  assign pready_o      = pready_r;
  assign pslverr_o     = pslverr_r;
  assign backup_trip_o = backup_trip_r;
  assign lock_o        = lock_r;
endmodule

//--- bf_pkg.sv
// Summary of operation
// - global setting picks current, position or combined check
// - current scheme: current held at threshold means failure
// - position scheme: no open indication means failure
// - combined: failure needs high current and no open
// - threshold and time come from active set 0..3
// - timer keeps running after trigger drops
// - expiry with the scheme's failure condition still met raises upstream backup trip
// - detected opening per scheme stops the timer
// - opening with triggers active: rejected until triggers drop
// - all triggers dropped: back to standby
// - lock rises with backup trip, held until acknowledged
// - three extra trigger inputs start supervision too
// - all-trips mode: any assigned trip starts timer
// - external mode: only external assigned trips start
// - current mode: only current protection trips start
// - unassigned mode: only extra inputs start supervision
// - current scheme: low current with open breaker no pickup
package bf_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  localparam logic [7:0]  OFF_CTRL       = 8'h00;
  localparam logic [7:0]  OFF_ACK        = 8'h04;
  localparam logic [7:0]  OFF_STATUS     = 8'h08;
  localparam logic [7:0]  OFF_SET_BASE   = 8'h10;
  localparam logic [7:0]  OFF_SET_LAST   = 8'h2c;
  localparam int          SET_IDX_LSB    = 3;
  localparam int          SET_TIME_BIT   = 2;
  localparam int          NUM_SETS       = 4;
  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int          CTRL_SCHEME_LSB = 0;
  localparam int          CTRL_TRIG_LSB   = 2;
  localparam int          CTRL_SET_LSB    = 4;
  localparam int          CTRL_EXTRA_LSB  = 6;
  localparam int          CTRL_W          = 9;
  localparam logic [8:0]  CTRL_RST        = 9'h1c0;
  localparam int          ACK_BIT         = 0;
  localparam int          ST_TRIP_BIT     = 4;
  localparam int          ST_LOCK_BIT     = 5;
  localparam int          ST_OPEN_BIT     = 6;
  localparam int          ST_HIGH_BIT     = 7;
  localparam int          ST_TRIG_BIT     = 8;
  localparam int          THR_W           = 16;
  localparam int          TIME_W          = 16;
  localparam logic [15:0] THR_RST         = 16'h0100;
  localparam logic [15:0] TIME_RST        = 16'h0064;
  localparam logic [1:0]  SCHEME_CURRENT  = 2'h0;
  localparam logic [1:0]  SCHEME_POSITION = 2'h1;
  localparam logic [1:0]  SCHEME_COMBINED = 2'h2;
  localparam logic [1:0]  MODE_ALL        = 2'h0;
  localparam logic [1:0]  MODE_EXTERNAL   = 2'h1;
  localparam logic [1:0]  MODE_CURRENT    = 2'h2;
  localparam logic [1:0]  MODE_UNASSIGNED = 2'h3;
  // ---------------------------------------------------------------
  // pins and timing
  // ---------------------------------------------------------------
  localparam int          PIN_W           = 5;
  localparam int          PIN_OPEN        = 0;
  localparam int          PIN_CLOSED      = 1;
  localparam int          PIN_EXTRA_LSB   = 2;
  localparam int          CLK_FREQ_MHZ    = 125;
  localparam int          TICK_PERIOD_US  = 1000;
  localparam int          TICK_CYCLES     = CLK_FREQ_MHZ * TICK_PERIOD_US;
  localparam int          TICK_W          = 17;
  typedef enum logic [3:0] {
    ST_STANDBY  = 4'b0001,
    ST_RUNNING  = 4'b0010,
    ST_REJECTED = 4'b0100,
    ST_FAILED   = 4'b1000
  } bf_state_t;
endpackage

//--- pin_sync_if.sv
`timescale 1ns/100ps
interface pin_sync_if;
  import bf_pkg::*;
  logic [PIN_W-1:0] raw;
  logic [PIN_W-1:0] clean;
  modport filter (input raw, output clean);
  modport user (output raw, input clean);
endinterface

//--- pin_sync.sv
`timescale 1ns/100ps
module pin_sync
  import bf_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  rst_b_i,
  pin_sync_if.filter pins
);
  // ---------------------------------------------------------------
  // three-stage capture; a level counts once stages two and three agree
  // ---------------------------------------------------------------
  logic [PIN_W-1:0] s1_r;
  logic [PIN_W-1:0] s2_r;
  logic [PIN_W-1:0] s3_r;
  logic [PIN_W-1:0] clean_r;

  genvar i;
  generate
    for (i = 0; i < PIN_W; i++) begin : g_bit
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          s1_r[i]    <= 1'b0;
          s2_r[i]    <= 1'b0;
          s3_r[i]    <= 1'b0;
          clean_r[i] <= 1'b0;
        end else begin
          s1_r[i] <= pins.raw[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          // stage one is never looked at here: it may be metastable
          if (s2_r[i] == s3_r[i]) begin
            clean_r[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate

  assign pins.clean = clean_r;
endmodule

//--- bf_breaker_model.sv
`timescale 1ns/100ps
module bf_breaker_model (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        open_cmd_i,
  input  wire logic        cur_stuck_i,
  input  wire logic        pos_stuck_i,
  input  wire logic [7:0]  delay_i,
  input  wire logic [15:0] load_i,
  output logic      [15:0] current_o,
  output logic             pos_open_o,
  output logic             pos_closed_o
);
  logic [7:0] cnt_r;
  logic       parted;
  // ---------------------------------------------------------------
  // breaker mechanics
  // ---------------------------------------------------------------
  // only a real trip command moves the breaker
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= 8'h00;
    end else if (!open_cmd_i) begin
      cnt_r <= 8'h00;
    end else if (cnt_r != 8'hff) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  // the opening delay stays well below the supervision time
  assign parted       = open_cmd_i && (cnt_r >= delay_i);
  // a stuck part keeps showing a closed breaker
  assign current_o    = (parted && !cur_stuck_i) ? 16'h0000 : load_i;
  assign pos_open_o   = parted && !pos_stuck_i;
  assign pos_closed_o = !pos_open_o;
endmodule

//--- breaker_failure_unit_props.sv
`timescale 1ns/100ps
module bf_props
  import bf_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
  input wire logic              clk_i,
  input wire logic              rst_b_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [DATA_W-1:0] pwdata_i,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  input wire logic              backup_trip_o,
  input wire logic              lock_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic        ack_wr;
  int unsigned hi_cnt_r;
  assign ack_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i == OFF_ACK && pwdata_i[ACK_BIT];
  // counts how long the backup trip has stood, so its minimum hold is visible
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hi_cnt_r <= 0;
    end else begin
      hi_cnt_r <= backup_trip_o ? hi_cnt_r + 1 : 0;
    end
  end
  a_ready_wait: assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o)
    else $error("pready not after one wait state");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  a_ready_access: assert property (pready_o |-> psel_i && penable_i)
    else $error("pready outside an access");
  a_bad_addr: assert property (pready_o && (paddr_i[1:0] != 2'h0 || paddr_i > OFF_SET_LAST || paddr_i == 8'h0c)
    |-> pslverr_o) else $error("unmapped access not refused");
  a_status_ok: assert property (pready_o && paddr_i == OFF_STATUS |-> !pslverr_o)
    else $error("status access refused");
  a_lock_with_trip: assert property ($rose(backup_trip_o) |-> lock_o)
    else $error("lock missing with backup trip");
  a_lock_rise_trip: assert property ($rose(lock_o) |-> $rose(backup_trip_o))
    else $error("lock rose without backup trip");
  a_lock_holds: assert property (lock_o && !ack_wr |=> lock_o)
    else $error("lock dropped without acknowledge");
  a_lock_ack_clear: assert property (ack_wr |-> ##[1:2] (!lock_o || backup_trip_o))
    else $error("acknowledge did not clear lock");
  a_trip_stands: assert property ($fell(backup_trip_o) |-> hi_cnt_r >= TICK_CYCLES_P)
    else $error("backup trip shorter than one tick");
  c_trip: cover property ($rose(backup_trip_o));
  c_ack: cover property ($fell(lock_o));
  c_err: cover property (pready_o && pslverr_o);
endmodule

bind breaker_failure_unit bf_props #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_props (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .backup_trip_o(backup_trip_o), .lock_o(lock_o));

//--- breaker_failure_unit_tb_top.sv
`timescale 1ns/100ps
module breaker_failure_unit_tb_top;
  import bf_pkg::*;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr, delay;
  logic [31:0] pwdata, prdata, q;
  logic        trip_all, trip_ext, trip_cur, pos_open, pos_closed;
  logic        backup_trip, lock, open_cmd, cur_stuck, pos_stuck, x;
  logic [2:0]  extra;
  logic [15:0] current;
  int          errors, comparisons, cycles;
  // short tick keeps supervision runs to a few dozen clocks
  breaker_failure_unit #(.TICK_CYCLES_P(8)) dut (
    .clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .trip_all_i(trip_all), .trip_ext_i(trip_ext), .trip_cur_i(trip_cur), .current_i(current),
    .pos_open_aux_i(pos_open), .pos_closed_aux_i(pos_closed), .extra_start_input_a_i(extra[0]),
    .extra_start_input_b_i(extra[1]), .extra_start_input_c_i(extra[2]),
    .backup_trip_o(backup_trip), .lock_o(lock));
  bf_breaker_model partner (
    .clk_i(clk), .rst_b_i(rst_b), .open_cmd_i(open_cmd), .cur_stuck_i(cur_stuck),
    .pos_stuck_i(pos_stuck), .delay_i(delay), .load_i(16'h0300), .current_o(current),
    .pos_open_o(pos_open), .pos_closed_o(pos_closed));
  always #4 clk = ~clk;
  // ---------------------------------------------------------------
  // reporting and bus tasks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] xp, input logic [31:0] g);
    comparisons++;
    if (g !== xp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, xp, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the cycle ceiling ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] xp);
    apb(1'b0, a, 32'h0);
    chk(n, xp, q);
  endtask
  task automatic trig(input int src, input logic on);
    trip_all <= on && src < 3;
    trip_ext <= on && src == 1;
    trip_cur <= on && src == 2;
    extra <= (on && src >= 3) ? 3'h1 << (src - 3) : 3'h0;
  endtask
  // one supervision run: trigger, let the timer decide, release, acknowledge
  task automatic run(input logic [1:0] sch, md, st, input int src, input logic cs, ps, pulse, xp);
    apb(1'b1, OFF_CTRL, {23'h0, 3'h7, st, md, sch});
    @(posedge clk);
    cur_stuck <= cs;
    pos_stuck <= ps;
    open_cmd <= 1'b1;
    trig(src, 1'b1);
    repeat (16) @(posedge clk);
    chk("early", 32'h0, {31'h0, backup_trip});
    if (pulse) trig(src, 1'b0);
    repeat (64) @(posedge clk);
    chk("trip", {31'h0, xp && !pulse}, {31'h0, backup_trip});
    chk("lock", {31'h0, xp}, {31'h0, lock});
    apb(1'b0, OFF_STATUS, 32'h0);
    if (xp && !pulse) chk("failed", 32'h8, q & 32'hf);
    else if (!cs && !ps) chk("rejected", 32'h4, q & 32'hf);
    trig(src, 1'b0);
    open_cmd <= 1'b0;
    repeat (24) @(posedge clk);
    chk("trip_off", 32'h0, {31'h0, backup_trip});
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("standby", 32'h1, q & 32'hf);
    chk("lock_kept", {31'h0, xp}, {31'h0, lock});
    apb(1'b1, OFF_ACK, 32'h1);
    repeat (2) @(posedge clk);
    chk("lock_ack", 32'h0, {31'h0, lock});
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 0;
    rst_b = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {trip_all, trip_ext, trip_cur, extra, open_cmd, cur_stuck, pos_stuck} = '0;
    {errors, comparisons, cycles} = '0;
    delay = 8'd20;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd("ctrl", OFF_CTRL, 32'h1c0);
    rd("status", OFF_STATUS, 32'h1 | (32'h1 << ST_HIGH_BIT));
    rd("thr0", 8'h10, 32'h100);
    rd("time0", 8'h14, 32'h64);
    apb(1'b1, OFF_STATUS, 32'hff);
    rd("status_ro", OFF_STATUS, 32'h1 | (32'h1 << ST_HIGH_BIT));
    apb(1'b0, 8'h0c, 32'h0);
    chk("err_gap", 32'h1, {31'h0, e});
    apb(1'b0, 8'h01, 32'h0);
    chk("err_align", 32'h1, {31'h0, e});
    apb(1'b1, 8'h18, 32'h200);
    apb(1'b1, 8'h1c, 32'h4);
    apb(1'b1, 8'h20, 32'h400);
    apb(1'b1, 8'h24, 32'h4);
    rd("thr1", 8'h18, 32'h200);
    for (int s = 0; s < 3; s++) begin
      for (int c = 0; c < 4; c++) begin
        x = (s == 0) ? c[0] : (s == 1) ? c[1] : (c[0] & c[1]);
        run(s[1:0], MODE_ALL, 2'h1, 0, c[0], c[1], 1'b0, x);
      end
    end
    run(SCHEME_CURRENT, MODE_ALL, 2'h2, 0, 1'b1, 1'b1, 1'b0, 1'b0);
    run(SCHEME_POSITION, MODE_ALL, 2'h1, 0, 1'b0, 1'b1, 1'b1, 1'b1);
    for (int m = 0; m < 4; m++) begin
      for (int src = 0; src < 6; src++) begin
        x = src >= 3 || (m == 0 && src < 3) || (m == 1 && src == 1) || (m == 2 && src == 2);
        run(SCHEME_POSITION, m[1:0], 2'h1, src, 1'b0, 1'b1, 1'b0, x);
      end
    end
    end_of_test();
  end
endmodule
